// ---- logic/synth_cfg_pkg.sv ----
// Register map, field layout and reset values of the synthesizer config slice.
// Assumes a register access port of word writes and reads at 7-bit addresses.
package synth_cfg_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int NUM_REGS = 14;

    // Register offsets
    localparam logic [6:0] OFF_PRESCALE = 7'h25;
    localparam logic [6:0] OFF_INTEGER = 7'h26;
    localparam logic [6:0] OFF_PFD_DELAY = 7'h27;
    localparam logic [6:0] OFF_DEN_HIGH = 7'h28;
    localparam logic [6:0] OFF_DEN_LOW = 7'h29;
    localparam logic [6:0] OFF_SEED_HIGH = 7'h2a;
    localparam logic [6:0] OFF_SEED_LOW = 7'h2b;
    localparam logic [6:0] OFF_NUM_HIGH = 7'h2c;
    localparam logic [6:0] OFF_NUM_LOW = 7'h2d;
    localparam logic [6:0] OFF_POWER_MOD = 7'h2e;
    localparam logic [6:0] OFF_A_SRC_B_POW = 7'h2f;
    localparam logic [6:0] OFF_B_SRC = 7'h30;
    localparam logic [6:0] OFF_STATUS_DRIVE = 7'h3b;
    localparam logic [6:0] OFF_LOCK_KIND = 7'h3d;
    localparam logic [6:0] OFF_READBACK = 7'h44;

    // Storage index of each register
    localparam int IDX_PRESCALE = 0;
    localparam int IDX_INTEGER = 1;
    localparam int IDX_PFD_DELAY = 2;
    localparam int IDX_DEN_HIGH = 3;
    localparam int IDX_DEN_LOW = 4;
    localparam int IDX_SEED_HIGH = 5;
    localparam int IDX_SEED_LOW = 6;
    localparam int IDX_NUM_HIGH = 7;
    localparam int IDX_NUM_LOW = 8;
    localparam int IDX_POWER_MOD = 9;
    localparam int IDX_A_SRC_B_POW = 10;
    localparam int IDX_B_SRC = 11;
    localparam int IDX_STATUS_DRIVE = 12;
    localparam int IDX_LOCK_KIND = 13;

    localparam logic [NUM_REGS-1:0][6:0] REG_OFFSET = {
        OFF_LOCK_KIND, OFF_STATUS_DRIVE, OFF_B_SRC, OFF_A_SRC_B_POW, OFF_POWER_MOD,
        OFF_NUM_LOW, OFF_NUM_HIGH, OFF_SEED_LOW, OFF_SEED_HIGH, OFF_DEN_LOW,
        OFF_DEN_HIGH, OFF_PFD_DELAY, OFF_INTEGER, OFF_PRESCALE};

    // Reset words; undocumented bits reset to zero
    localparam logic [NUM_REGS-1:0][15:0] REG_RESET = {
        16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0f80,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h03e8,
        16'h03e8, 16'h0200, 16'h0036, 16'h0000};

    // Field positions
    localparam int PRESCALE_BIT = 12;
    localparam int INT_MSB = 12;
    localparam int INT_LSB = 1;
    localparam int DLY_MSB = 13;
    localparam int DLY_LSB = 8;
    localparam int POW_A_MSB = 13;
    localparam int POW_A_LSB = 8;
    localparam int PD_B_BIT = 7;
    localparam int PD_A_BIT = 6;
    localparam int ORDER_MSB = 2;
    localparam int SRC_A_MSB = 12;
    localparam int SRC_A_LSB = 11;
    localparam int POW_B_MSB = 5;
    localparam int SRC_B_MSB = 1;
    localparam int HDRV_BIT = 5;
    localparam int KIND_BIT = 0;
    localparam int RB_MSB = 10;
    localparam int RB_LSB = 9;

    // Field values
    localparam logic [11:0] INT_RESET = 12'h01b;
    localparam logic [5:0] DLY_CODE_4 = 6'h01;
    localparam logic [5:0] DLY_CODE_6 = 6'h02;
    localparam logic [5:0] DLY_CODE_8 = 6'h04;
    localparam logic [5:0] DLY_CODE_12 = 6'h08;
    localparam logic [5:0] DLY_CODE_16 = 6'h10;
    localparam logic [4:0] DLY_CYC_4 = 5'h04;
    localparam logic [4:0] DLY_CYC_6 = 5'h06;
    localparam logic [4:0] DLY_CYC_8 = 5'h08;
    localparam logic [4:0] DLY_CYC_12 = 5'h0c;
    localparam logic [4:0] DLY_CYC_16 = 5'h10;
    localparam logic [5:0] POW_LINEAR_MAX = 6'h1f;
    localparam logic [5:0] POW_BOOST_MIN = 6'h30;
    localparam logic [2:0] ORDER_MAX = 3'h4;
    localparam logic [1:0] SRC_VCO = 2'h1;
    localparam logic [1:0] TUNE_LOCKED = 2'h2;
endpackage

// ---- logic/lock_status_select.sv ----
// Picks the level of the multiplexed status pin from the lock-detect sources.
// Assumes its inputs are flip-flop outputs or synchronous to the same clock.
`timescale 1ns/1ps
module lock_status_select (
    input wire logic function_sel_lock, // Status pin set to lock-detect function
    input wire logic lock_detect_kind, // 0 calibration status, 1 tuning detect
    input wire logic calibration_done, // Auto calibration finished successfully
    input wire logic [1:0] tuning_state, // Tuning-voltage detector code
    output logic pin_level // Level the status pin should show
);
    // Other pin functions are outside this slice, so the pin rests low there
    always_comb begin
        if (!function_sel_lock) begin
            pin_level = 1'b0;
        end else if (lock_detect_kind) begin
            pin_level = (tuning_state == synth_cfg_pkg::TUNE_LOCKED);
        end else begin
            pin_level = calibration_done;
        end
    end
endmodule

// ---- logic/synth_divider_output_config_regs.sv ----
// Configuration register slice: feedback divider, fraction, modulator,
// output buffers and the lock-detect status pin.
// Assumes a serial front end outside turns frames into single-cycle word
// writes and reads on the register port, synchronous to clk.
`timescale 1ns/1ps
module synth_divider_output_config_regs #(
    parameter int ADDR_W = synth_cfg_pkg::ADDR_W
) (
    input wire logic clk, // 40 MHz clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic reg_write, // Write strobe, one cycle
    input wire logic reg_read, // Read strobe, one cycle
    input wire logic [ADDR_W-1:0] reg_addr, // Register address
    input wire logic [15:0] reg_wdata, // Write data
    output logic [15:0] reg_rdata, // Read data, held until next read
    output logic reg_rvalid, // Read data valid, one cycle
    input wire logic status_pin_function_sel, // 1 puts lock detect on the pin
    input wire logic calibration_done, // Calibration completed successfully
    input wire logic [1:0] tuning_lock_state, // Tuning-voltage detector code
    output logic status_pin, // Multiplexed status pin level
    output logic status_pin_high_drive, // Stronger pin drive enable
    output logic lock_detect_kind, // Lock-detect flavour
    output logic [1:0] tuning_lock_readback, // Tuning lock code as read back
    output logic prescale_div4, // Feedback pre-scaler divides by four
    output logic [11:0] feedback_integer, // Integer part of feedback ratio
    output logic [5:0] phase_detector_delay, // Raw one-hot delay code
    output logic [4:0] phase_detector_delay_cycles, // Delay in cycles, 0 if invalid
    output logic [31:0] fraction_denominator, // Fraction denominator
    output logic [31:0] fraction_numerator, // Fraction numerator
    output logic [31:0] modulator_seed, // Modulator seed
    output logic [2:0] modulator_order, // Modulator order code
    output logic fractional_mode, // Modulator active
    output logic modulator_order_valid, // Order code in 0..4
    output logic [5:0] output_a_power_level, // Buffer A power code
    output logic [5:0] output_b_power_level, // Buffer B power code
    output logic output_a_power_boost, // Buffer A in boost range
    output logic output_b_power_boost, // Buffer B in boost range
    output logic output_a_power_valid, // Buffer A code not in 32..47
    output logic output_b_power_valid, // Buffer B code not in 32..47
    output logic output_a_power_down, // Buffer A powered down
    output logic output_b_power_down, // Buffer B powered down
    output logic [1:0] output_a_source_sel, // Buffer A source
    output logic [1:0] output_b_source_sel, // Buffer B source
    output logic output_a_source_valid, // Buffer A source not reserved
    output logic output_b_source_valid // Buffer B source not reserved
);
    localparam int N = synth_cfg_pkg::NUM_REGS;

    // Addresses narrower than the map cannot reach the upper registers
    if (ADDR_W < synth_cfg_pkg::ADDR_W) begin : g_addr_check
        $error("reg_addr is too narrow for the register map");
    end

    typedef struct packed {
        logic [N-1:0][15:0] regs;
        logic [15:0] rdata;
        logic rvalid;
        logic pin;
    } state_t;

    state_t st;
    state_t next_st;
    logic [N-1:0] hit;
    logic [15:0] read_word;
    logic pin_level;

    // One address comparator per register
    for (genvar i = 0; i < N; i++) begin : g_hit
        assign hit[i] = (reg_addr == ADDR_W'(synth_cfg_pkg::REG_OFFSET[i]));
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        read_word = 16'h0000;
        for (int i = 0; i < N; i++) begin
            if (hit[i]) begin
                read_word = st.regs[i];
            end
        end
        if (reg_addr == ADDR_W'(synth_cfg_pkg::OFF_READBACK)) begin
            read_word[synth_cfg_pkg::RB_MSB:synth_cfg_pkg::RB_LSB] = tuning_lock_state;
        end
    end

    lock_status_select u_lock_status_select (
        .function_sel_lock(status_pin_function_sel),
        .lock_detect_kind(lock_detect_kind),
        .calibration_done(calibration_done),
        .tuning_state(tuning_lock_state),
        .pin_level(pin_level)
    );

    // Next state: every word is plain read/write, the readback is read only
    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.pin = pin_level;
        if (reg_write) begin
            for (int i = 0; i < N; i++) begin
                if (hit[i]) begin
                    next_st.regs[i] = reg_wdata;
                end
            end
        end
        if (reg_read) begin
            next_st.rdata = read_word;
            next_st.rvalid = 1'b1;
        end
        if (srst) begin
            next_st.regs = synth_cfg_pkg::REG_RESET;
            next_st.rdata = 16'h0000;
            next_st.rvalid = 1'b0;
            next_st.pin = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // Register port answers, status pin and tuning readback
    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign status_pin = st.pin;
    assign tuning_lock_readback = tuning_lock_state;

    // Divider fields
    assign prescale_div4 =
        st.regs[synth_cfg_pkg::IDX_PRESCALE][synth_cfg_pkg::PRESCALE_BIT];
    assign feedback_integer =
        st.regs[synth_cfg_pkg::IDX_INTEGER][synth_cfg_pkg::INT_MSB:synth_cfg_pkg::INT_LSB];
    assign phase_detector_delay =
        st.regs[synth_cfg_pkg::IDX_PFD_DELAY][synth_cfg_pkg::DLY_MSB:synth_cfg_pkg::DLY_LSB];
    assign fraction_denominator = {st.regs[synth_cfg_pkg::IDX_DEN_HIGH],
        st.regs[synth_cfg_pkg::IDX_DEN_LOW]};
    assign fraction_numerator = {st.regs[synth_cfg_pkg::IDX_NUM_HIGH],
        st.regs[synth_cfg_pkg::IDX_NUM_LOW]};
    assign modulator_seed = {st.regs[synth_cfg_pkg::IDX_SEED_HIGH],
        st.regs[synth_cfg_pkg::IDX_SEED_LOW]};

    // Delay decode; the unused code and non-one-hot values give zero cycles
    always_comb begin
        case (phase_detector_delay)
            synth_cfg_pkg::DLY_CODE_4: phase_detector_delay_cycles = synth_cfg_pkg::DLY_CYC_4;
            synth_cfg_pkg::DLY_CODE_6: phase_detector_delay_cycles = synth_cfg_pkg::DLY_CYC_6;
            synth_cfg_pkg::DLY_CODE_8: phase_detector_delay_cycles = synth_cfg_pkg::DLY_CYC_8;
            synth_cfg_pkg::DLY_CODE_12: phase_detector_delay_cycles = synth_cfg_pkg::DLY_CYC_12;
            synth_cfg_pkg::DLY_CODE_16: phase_detector_delay_cycles = synth_cfg_pkg::DLY_CYC_16;
            default: phase_detector_delay_cycles = 5'h00;
        endcase
    end

    // Modulator order
    assign modulator_order =
        st.regs[synth_cfg_pkg::IDX_POWER_MOD][synth_cfg_pkg::ORDER_MSB:0];
    assign fractional_mode = (modulator_order != 3'h0);
    assign modulator_order_valid = (modulator_order <= synth_cfg_pkg::ORDER_MAX);

    // Output buffers
    assign output_a_power_level =
        st.regs[synth_cfg_pkg::IDX_POWER_MOD][synth_cfg_pkg::POW_A_MSB:synth_cfg_pkg::POW_A_LSB];
    assign output_b_power_level =
        st.regs[synth_cfg_pkg::IDX_A_SRC_B_POW][synth_cfg_pkg::POW_B_MSB:0];
    // Codes 32..47 are undocumented, so they are flagged rather than trusted
    assign output_a_power_boost = (output_a_power_level >= synth_cfg_pkg::POW_BOOST_MIN);
    assign output_b_power_boost = (output_b_power_level >= synth_cfg_pkg::POW_BOOST_MIN);
    assign output_a_power_valid = (output_a_power_level <= synth_cfg_pkg::POW_LINEAR_MAX)
        || output_a_power_boost;
    assign output_b_power_valid = (output_b_power_level <= synth_cfg_pkg::POW_LINEAR_MAX)
        || output_b_power_boost;
    assign output_a_power_down =
        st.regs[synth_cfg_pkg::IDX_POWER_MOD][synth_cfg_pkg::PD_A_BIT];
    assign output_b_power_down =
        st.regs[synth_cfg_pkg::IDX_POWER_MOD][synth_cfg_pkg::PD_B_BIT];
    assign output_a_source_sel =
        st.regs[synth_cfg_pkg::IDX_A_SRC_B_POW][synth_cfg_pkg::SRC_A_MSB:synth_cfg_pkg::SRC_A_LSB];
    assign output_b_source_sel =
        st.regs[synth_cfg_pkg::IDX_B_SRC][synth_cfg_pkg::SRC_B_MSB:0];
    assign output_a_source_valid = (output_a_source_sel <= synth_cfg_pkg::SRC_VCO);
    assign output_b_source_valid = (output_b_source_sel <= synth_cfg_pkg::SRC_VCO);

    // Status pin controls
    assign status_pin_high_drive =
        st.regs[synth_cfg_pkg::IDX_STATUS_DRIVE][synth_cfg_pkg::HDRV_BIT];
    assign lock_detect_kind =
        st.regs[synth_cfg_pkg::IDX_LOCK_KIND][synth_cfg_pkg::KIND_BIT];

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_write(logic [6:0] off);
        reg_write && (reg_addr == ADDR_W'(off));
    endsequence

    sequence s_read(logic [6:0] off);
        reg_read && (reg_addr == ADDR_W'(off));
    endsequence

    a_prescale_ratio: assert property (
        s_write(synth_cfg_pkg::OFF_PRESCALE) |=>
            (prescale_div4 == $past(reg_wdata[synth_cfg_pkg::PRESCALE_BIT])))
        else $error("pre-scaler bit did not follow the write");

    a_integer_reset: assert property (@(posedge clk) disable iff (1'b0)
        srst ##1 !srst |-> (feedback_integer == synth_cfg_pkg::INT_RESET)
            && (phase_detector_delay_cycles == synth_cfg_pkg::DLY_CYC_6))
        else $error("integer or delay reset value wrong");

    a_delay_decode: assert property (
        s_write(synth_cfg_pkg::OFF_PFD_DELAY)
            ##0 (reg_wdata[synth_cfg_pkg::DLY_MSB:synth_cfg_pkg::DLY_LSB] == 6'h08)
            |=> (phase_detector_delay_cycles == synth_cfg_pkg::DLY_CYC_12))
        else $error("delay code 8 did not give 12 cycles");

    a_denominator_split: assert property (
        s_write(synth_cfg_pkg::OFF_DEN_HIGH) |=>
            (fraction_denominator[31:16] == $past(reg_wdata))
            && $stable(fraction_denominator[15:0]))
        else $error("denominator high half wrong");

    a_numerator_split: assert property (
        s_write(synth_cfg_pkg::OFF_NUM_LOW) |=>
            (fraction_numerator[15:0] == $past(reg_wdata))
            && $stable(fraction_numerator[31:16]))
        else $error("numerator low half wrong");

    a_power_boost: assert property (
        s_write(synth_cfg_pkg::OFF_A_SRC_B_POW) |=>
            (output_b_power_boost == ($past(reg_wdata[5:0]) >= 6'h30)))
        else $error("buffer B boost flag wrong");

    a_powerdown_reset: assert property (@(posedge clk) disable iff (1'b0)
        srst ##1 !srst |-> output_b_power_down && !output_a_power_down
            && (output_a_power_level == 6'h0f))
        else $error("buffer power-down reset wrong");

    a_order_mode: assert property (
        s_write(synth_cfg_pkg::OFF_POWER_MOD) |=>
            (fractional_mode == ($past(reg_wdata[2:0]) != 3'h0)))
        else $error("integer mode not following order code");

    a_source_reserved: assert property (
        s_write(synth_cfg_pkg::OFF_B_SRC) ##0 reg_wdata[1] |=> !output_b_source_valid)
        else $error("reserved source code accepted");

    a_pin_calibration: assert property (
        status_pin_function_sel && !lock_detect_kind |=> (status_pin == $past(calibration_done)))
        else $error("status pin not showing calibration state");

    a_pin_tuning: assert property (
        status_pin_function_sel && lock_detect_kind
            |=> (status_pin == ($past(tuning_lock_state) == synth_cfg_pkg::TUNE_LOCKED)))
        else $error("status pin not showing tuning lock");

    a_readback_code: assert property (
        s_read(synth_cfg_pkg::OFF_READBACK) |=> reg_rvalid
            && (reg_rdata[synth_cfg_pkg::RB_MSB:synth_cfg_pkg::RB_LSB] == $past(tuning_lock_state)))
        else $error("tuning lock readback wrong");
endmodule

// ---- verification/host_cfg_model.sv ----
// Host controller model: word writes and reads on the register port.
// Assumes the bench calls its tasks from one process, one request at a time.
`timescale 1ns/1ps
module host_cfg_model (
    input wire logic clk, // Register port clock
    output logic reg_write, // Write strobe
    output logic reg_read, // Read strobe
    output logic [6:0] reg_addr, // Word address
    output logic [15:0] reg_wdata, // Write word
    input wire logic [15:0] reg_rdata, // Read word
    input wire logic reg_rvalid // Read answer strobe
);
    // Named field bits by storage index; the other bits keep their defaults
    localparam logic [13:0][15:0] FIELD_MASK = {16'h0001, 16'h0020, 16'h0003, 16'h183f,
        16'h3fc7, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h3f00,
        16'h1ffe, 16'h1000};

    // Idle port at time zero
    initial begin
        {reg_write, reg_read, reg_addr, reg_wdata} = 25'h000_0000;
    end

    // Storage index of an address, -1 when unmapped
    function automatic int index_of(input logic [6:0] a);
        for (int i = 0; i < synth_cfg_pkg::NUM_REGS; i++) begin
            if (synth_cfg_pkg::REG_OFFSET[i] == a) begin
                return i;
            end
        end
        return -1;
    endfunction

    // Unnamed ranges of mapped words go out with their default contents; unmapped words go out as given
    function automatic logic [15:0] host_word(input logic [6:0] a, input logic [15:0] d);
        int i;
        i = index_of(a);
        if (i < 0) begin
            return d;
        end
        return (d & FIELD_MASK[i]) | (synth_cfg_pkg::REG_RESET[i] & ~FIELD_MASK[i]);
    endfunction

    // One-cycle write; released lines are inverted so stale values never look valid
    task automatic write_reg(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = host_word(a, d);
        reg_write = 1'h1;
        @(negedge clk);
        reg_write = 1'h0;
        reg_addr = ~a;
        reg_wdata = ~reg_wdata;
    endtask

    // One-cycle read; the answer is taken in the cycle after the request edge
    task automatic read_reg(input logic [6:0] a, output logic [15:0] d, output logic ok);
        @(negedge clk);
        reg_addr = a;
        reg_read = 1'h1;
        @(negedge clk);
        reg_read = 1'h0;
        reg_addr = ~a;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule

// ---- verification/tb_synth_divider_output_config_regs.sv ----
// Self-checking bench of the synthesizer config register slice.
// Assumes host_cfg_model drives the register port; inputs change at falling edges.
`timescale 1ns/1ps
module tb_synth_divider_output_config_regs;
    logic clk, srst, reg_write, reg_read, reg_rvalid, status_pin_function_sel, calibration_done;
    logic [6:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, r, dh;
    logic status_pin, status_pin_high_drive, lock_detect_kind, prescale_div4, fractional_mode;
    logic [1:0] tuning_lock_state, tuning_lock_readback, output_a_source_sel, output_b_source_sel;
    logic [11:0] feedback_integer;
    logic [5:0] phase_detector_delay, output_a_power_level, output_b_power_level, pw;
    logic [4:0] phase_detector_delay_cycles;
    logic [31:0] fraction_denominator, fraction_numerator, modulator_seed;
    logic [2:0] modulator_order;
    logic modulator_order_valid, output_a_power_boost, output_b_power_boost;
    logic output_a_power_valid, output_b_power_valid, output_a_power_down, output_b_power_down;
    logic output_a_source_valid, output_b_source_valid;
    logic [15:0] shadow [14];
    logic [15:0] lfsr_state = 16'h05a8;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0, k;

    synth_divider_output_config_regs u_synth_divider_output_config_regs (
        .clk(clk), .srst(srst), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .status_pin_function_sel(status_pin_function_sel),
        .calibration_done(calibration_done), .tuning_lock_state(tuning_lock_state),
        .status_pin(status_pin), .status_pin_high_drive(status_pin_high_drive),
        .lock_detect_kind(lock_detect_kind), .tuning_lock_readback(tuning_lock_readback),
        .prescale_div4(prescale_div4), .feedback_integer(feedback_integer),
        .phase_detector_delay(phase_detector_delay),
        .phase_detector_delay_cycles(phase_detector_delay_cycles),
        .fraction_denominator(fraction_denominator), .fraction_numerator(fraction_numerator),
        .modulator_seed(modulator_seed), .modulator_order(modulator_order),
        .fractional_mode(fractional_mode), .modulator_order_valid(modulator_order_valid),
        .output_a_power_level(output_a_power_level), .output_b_power_level(output_b_power_level),
        .output_a_power_boost(output_a_power_boost), .output_b_power_boost(output_b_power_boost),
        .output_a_power_valid(output_a_power_valid), .output_b_power_valid(output_b_power_valid),
        .output_a_power_down(output_a_power_down), .output_b_power_down(output_b_power_down),
        .output_a_source_sel(output_a_source_sel), .output_b_source_sel(output_b_source_sel),
        .output_a_source_valid(output_a_source_valid),
        .output_b_source_valid(output_b_source_valid));

    host_cfg_model u_host_cfg_model (.clk(clk), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    // 40 MHz clock
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    // Fixed-seed pseudo-random words keep every run identical
    function automatic logic [15:0] rnd();
        lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12]
            ^ lfsr_state[10]};
        return lfsr_state;
    endfunction

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask

    // Write through the host and track what each register should now hold
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        int i;
        i = u_host_cfg_model.index_of(a);
        u_host_cfg_model.write_reg(a, d);
        if (i >= 0) begin
            shadow[i] = u_host_cfg_model.host_word(a, d);
        end
    endtask

    task automatic rd_cmp(input logic [6:0] a, input logic [15:0] exp, input string what);
        logic [15:0] d;
        logic ok;
        u_host_cfg_model.read_reg(a, d, ok);
        check("read valid", ok, 1'h1);
        check(what, d, exp);
    endtask

    function automatic logic [4:0] exp_delay(input logic [5:0] code);
        case (code)
            6'h01: return 5'h04;
            6'h02: return 5'h06;
            6'h04: return 5'h08;
            6'h08: return 5'h0c;
            6'h10: return 5'h10;
            default: return 5'h00;
        endcase
    endfunction

    function automatic logic exp_pin(input logic [3:0] in, input logic kind);
        return in[3] & (kind ? (in[1:0] == 2'h2) : in[2]);
    endfunction

    // Hang guard, far above the roughly 450 cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            $display("Timeout after %0d cycles", cycles);
            summarize();
        end
    end

    // Main sequence
    initial begin
        srst = 1'h1;
        {status_pin_function_sel, calibration_done, tuning_lock_state} = 4'h0;
        repeat (12) @(negedge clk);
        srst = 1'h0;
        for (int i = 0; i < 14; i++) begin
            shadow[i] = synth_cfg_pkg::REG_RESET[i];
            rd_cmp(synth_cfg_pkg::REG_OFFSET[i], shadow[i], "reset word");
        end
        check("reset fields", {feedback_integer, phase_detector_delay, output_a_power_level,
            output_b_power_level, output_b_power_down, output_a_power_down, output_a_source_sel,
            lock_detect_kind}, {12'h01b, 6'h02, 6'h0f, 6'h00, 2'h2, 2'h0, 1'h1});
        check("reset fraction", {fraction_denominator, fraction_numerator},
            64'h03e8_03e8_0000_0000);
        done("reset");
        wr(synth_cfg_pkg::OFF_PRESCALE, 16'h1000);
        check("div4", prescale_div4, 1'h1);
        wr(synth_cfg_pkg::OFF_PRESCALE, 16'hefff);
        check("div2", prescale_div4, 1'h0);
        for (int i = 0; i < 3; i++) begin
            r = rnd();
            r = (i == 0) ? 16'h0000 : ((i == 1) ? 16'hffff : r);
            wr(synth_cfg_pkg::OFF_INTEGER, r);
            check("integer", feedback_integer, r[12:1]);
        end
        for (int i = 0; i < 6; i++) begin
            wr(synth_cfg_pkg::OFF_PFD_DELAY, {2'h0, 6'h01 << i, 8'h00});
            check("delay", phase_detector_delay_cycles, exp_delay(6'h01 << i));
        end
        done("divider");
        r = rnd();
        dh = r | 16'h0002;
        r = rnd();
        wr(synth_cfg_pkg::OFF_DEN_HIGH, dh);
        check("den high", fraction_denominator, {dh, 16'h03e8});
        wr(synth_cfg_pkg::OFF_DEN_LOW, r);
        check("den", fraction_denominator, {dh, r});
        wr(synth_cfg_pkg::OFF_NUM_HIGH, dh >> 1);
        check("num high", fraction_numerator, {dh >> 1, 16'h0000});
        wr(synth_cfg_pkg::OFF_NUM_LOW, ~r);
        check("num", fraction_numerator, {dh >> 1, ~r});
        wr(synth_cfg_pkg::OFF_SEED_HIGH, ~dh);
        wr(synth_cfg_pkg::OFF_SEED_LOW, r);
        check("seed", modulator_seed, {~dh, r});
        done("fraction");
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            pw = (i == 0) ? 6'h00 : (i == 1) ? 6'h1f : (i == 2) ? 6'h20 : (i == 3) ? 6'h2f
                : (i == 4) ? 6'h30 : (i == 5) ? 6'h3f : r[5:0];
            wr(synth_cfg_pkg::OFF_POWER_MOD, {2'h0, pw, i[1:0], 3'h0, i[2:0]});
            wr(synth_cfg_pkg::OFF_A_SRC_B_POW, {1'h0, i[3:0] & 4'h3, 5'h00, ~pw});
            wr(synth_cfg_pkg::OFF_B_SRC, {14'h0000, ~i[1:0]});
            check("power a", {output_a_power_level, output_a_power_boost, output_a_power_valid},
                {pw, pw >= 6'h30, pw <= 6'h1f || pw >= 6'h30});
            check("power b", {output_b_power_level, output_b_power_boost, output_b_power_valid},
                {~pw, ~pw >= 6'h30, ~pw <= 6'h1f || ~pw >= 6'h30});
            check("down", {output_b_power_down, output_a_power_down}, i[1:0]);
            check("order", {modulator_order, fractional_mode, modulator_order_valid},
                {i[2:0], i[2:0] != 3'h0, i[2:0] <= 3'h4});
            check("source", {output_a_source_sel, output_b_source_sel, output_a_source_valid,
                output_b_source_valid}, {i[1:0], ~i[1:0], i[1:0] <= 2'h1, ~i[1:0] <= 2'h1});
        end
        done("outputs");
        for (int kd = 0; kd < 2; kd++) begin
            wr(synth_cfg_pkg::OFF_LOCK_KIND, {15'h0000, kd[0]});
            for (int j = 0; j < 16; j++) begin
                @(negedge clk);
                {status_pin_function_sel, calibration_done, tuning_lock_state} = j[3:0];
                @(negedge clk);
                check("status pin", status_pin, exp_pin(j[3:0], kd[0]));
                check("tune comb", tuning_lock_readback, j[1:0]);
                rd_cmp(7'h44, {5'h00, j[1:0], 9'h000}, "tune read");
            end
        end
        done("status");
        for (int n = 0; n < 40; n++) begin
            r = rnd();
            k = r % 14;
            k = (k >= 3 && k <= 8) ? 9 + k % 5 : k;
            r = rnd();
            wr(synth_cfg_pkg::REG_OFFSET[k], r);
            rd_cmp(synth_cfg_pkg::REG_OFFSET[k], shadow[k], "random word");
        end
        wr(7'h44, 16'hffff);
        wr(7'h7f, 16'hffff);
        rd_cmp(7'h7f, 16'h0000, "unmapped");
        check("high drive", status_pin_high_drive, shadow[12][5]);
        for (int i = 0; i < 14; i++) begin
            rd_cmp(synth_cfg_pkg::REG_OFFSET[i], shadow[i], "final word");
        end
        done("random");
        summarize();
    end
endmodule
